// ### common/uhr_defines.vh
// constants for the usb host register front end
`ifndef UHR_DEFINES_VH
`define UHR_DEFINES_VH
// ---------------------------------------------
// i/o register byte offsets
// ---------------------------------------------
`define UHR_OFF_CMD 8'h00
`define UHR_OFF_STS 8'h02
`define UHR_OFF_INTR 8'h04
`define UHR_OFF_FRNO 8'h06
`define UHR_OFF_BASE_LO 8'h08
`define UHR_OFF_BASE_HI 8'h0a
`define UHR_OFF_SOF 8'h0c
`define UHR_OFF_PORT0 8'h10
`define UHR_OFF_PORT1 8'h12
`define UHR_OFF_LOOP 8'h18
// configuration offset of the wake enable byte
`define UHR_OFF_WAKE 8'hc4
// ---------------------------------------------
// reset values
// ---------------------------------------------
`define UHR_RST_CMD 16'h0000
`define UHR_RST_STS 5'h00
`define UHR_RST_SOF 8'h40
`define UHR_RST_PORT 16'h0080
`define UHR_RST_WAKE 2'h0
// ---------------------------------------------
// command bit positions
// ---------------------------------------------
`define UHR_CMD_RUN 0
`define UHR_CMD_HCRST 1
`define UHR_CMD_GRST 2
`define UHR_CMD_GSUSP 3
`define UHR_CMD_FGR 4
`define UHR_CMD_DBG 5
`define UHR_CMD_RECLAIM_PACKET_SIZE_SELECT 7
`define UHR_CMD_LOOP 8
`define UHR_CMD_MASK 16'h01ff
// ---------------------------------------------
// status bit positions
// ---------------------------------------------
`define UHR_STS_BABBLE 1
`define UHR_STS_RESUME 2
`define UHR_STS_HALT 5
// ---------------------------------------------
// port control bit positions
// ---------------------------------------------
`define UHR_PC_CONN 0
`define UHR_PC_CCHG 1
`define UHR_PC_EN 2
`define UHR_PC_ECHG 3
`define UHR_PC_RSM 6
`define UHR_PC_PRST 9
`define UHR_PC_SUSP 12
// ---------------------------------------------
// reclamation limits: packet sizes in bytes, reserve in bit times
// ---------------------------------------------
`define UHR_PKT_BYTES_64 8'h40
`define UHR_PKT_BYTES_32 8'h20
`define UHR_RECLAIM_BITS_64 12'h200
`define UHR_RECLAIM_BITS_32 12'h100
`endif

// ### hw/uhr_port.v
// one downstream port: pin sync, live status and wake detect
`default_nettype none
module uhr_port
(
   // clock and reset
   input wire sys_clk,
   input wire rst,
   // pins from the port transceiver
   input wire connect_pin,
   input wire kstate_pin,
   // word write to this port register
   input wire wr_en,
   input wire [15:0] wdata,
   // controller wide reset and wake enable
   input wire force_off,
   input wire wake_en,
   // status back to the top
   output wire [15:0] ctl_rd,
   output reg wake_ff,
   output reg abort_ff
);
`include "uhr_defines.vh"
   // ---------------------------------------------
   // pin synchronisers
   // ---------------------------------------------
   reg [1:0] conn_sync_ff; // [0] is read only by [1]
   reg [1:0] ks_sync_ff;
   reg conn_ff; // last seen connect level
   reg cchg_ff, en_ff, echg_ff, rsm_ff, prst_ff, susp_ff;
   wire conn_edge = conn_sync_ff[1] ^ conn_ff;
   // remote wakeup is a k state while suspended
   wire rsm_evt = ks_sync_ff[1] & susp_ff & ~rsm_ff;
   // any reset that must end traffic on this port
   wire kill = force_off | prst_ff | (wr_en & wdata[`UHR_PC_PRST]);
   always @(posedge sys_clk)
   begin
      conn_sync_ff <= {conn_sync_ff[0], connect_pin};
      ks_sync_ff <= {ks_sync_ff[0], kstate_pin};
   end
   // ---------------------------------------------
   // status and control state
   // ---------------------------------------------
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         conn_ff <= 1'b0;
         cchg_ff <= 1'b0;
         en_ff <= 1'b0;
         echg_ff <= 1'b0;
         rsm_ff <= 1'b0;
         prst_ff <= 1'b0;
         susp_ff <= 1'b0;
         wake_ff <= 1'b0;
         abort_ff <= 1'b0;
      end
      else
      begin
         conn_ff <= conn_sync_ff[1];
         // change flags: a new event beats the write-one clear
         cchg_ff <= conn_edge | (cchg_ff & ~(wr_en & wdata[`UHR_PC_CCHG]));
         echg_ff <= (en_ff & (kill | conn_edge))
                    | (echg_ff & ~(wr_en & wdata[`UHR_PC_ECHG]));
         if (kill | ~conn_sync_ff[1])
            en_ff <= 1'b0;
         else if (wr_en)
            en_ff <= wdata[`UHR_PC_EN];
         if (kill)
            rsm_ff <= 1'b0;
         else if (rsm_evt)
            rsm_ff <= 1'b1;
         if (kill & ~wr_en)
            susp_ff <= 1'b0;
         else if (force_off)
            susp_ff <= 1'b0;
         else if (wr_en)
            susp_ff <= wdata[`UHR_PC_SUSP] & ~wdata[`UHR_PC_PRST];
         if (force_off)
            prst_ff <= 1'b0;
         else if (wr_en)
            prst_ff <= wdata[`UHR_PC_PRST];
         wake_ff <= wake_en & (rsm_evt | conn_edge);
         abort_ff <= kill & en_ff;
      end
   end
   assign ctl_rd = {3'h0, susp_ff, 2'h0, prst_ff, 2'h0, rsm_ff, 2'h0,
                    echg_ff, en_ff, cchg_ff, conn_ff} | `UHR_RST_PORT;
endmodule // uhr_port
`default_nettype wire

// ### hw/uhr_regs.v
// usb host register front end: config wake byte and i/o registers
`default_nettype none
module uhr_regs
#(
   parameter NPORT = 2 // downstream ports
)
(
   // clock and reset
   input wire sys_clk,
   input wire rst,
   // register access port
   input wire cfg_sel,
   input wire [7:0] acc_addr,
   input wire acc_wr,
   input wire acc_rd,
   input wire [1:0] acc_be,
   input wire [15:0] acc_wdata,
   output reg [15:0] acc_rdata_ff,
   output reg acc_rvalid_ff,
   // port pins
   input wire [NPORT-1:0] port_connect,
   input wire [NPORT-1:0] port_kstate,
   // transaction engine status
   input wire xact_done,
   input wire [11:0] frame_time_left,
   input wire reclaim_active,
   input wire [7:0] reclaim_bytes,
   input wire lb_rx_stb,
   input wire [7:0] lb_rx_data,
   // controls to the transaction engine
   output reg run_ff,
   output reg cmd_exec_ff,
   output reg [15:0] cmd_out_ff,
   output reg start_ok_ff,
   output reg babble_ff,
   output reg stall_ep_ff,
   output reg [7:0] sof_adjust_ff,
   output reg [31:0] frame_base_ff,
   output reg [15:0] frame_index_ff,
   // port side results
   output reg [NPORT-1:0] port_enabled_ff,
   output reg [NPORT-1:0] xfer_abort_ff,
   output reg wake_event_ff
);
`include "uhr_defines.vh"
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   // merge enabled byte lanes of a write
   function [15:0] lane_merge;
      input [15:0] old_v;
      input [15:0] new_v;
      input [1:0] be;
      begin
         lane_merge = {be[1] ? new_v[15:8] : old_v[15:8],
                       be[0] ? new_v[7:0] : old_v[7:0]};
      end
   endfunction
   // byte offset of the register of a given port, kept at eight bits
   function [7:0] port_off;
      input integer idx;
      begin
         port_off = `UHR_OFF_PORT0 + {idx[6:0], 1'b0};
      end
   endfunction
   // one io write hit on a given offset
   function io_hit;
      input [7:0] addr;
      input [7:0] off;
      begin
         io_hit = acc_wr & ~cfg_sel & (addr[7:1] == off[7:1]);
      end
   endfunction
   // ---------------------------------------------
   // storage
   // ---------------------------------------------
   reg [15:0] cmd_ff; // command register
   reg [4:0] sts_ff; // sticky status flags
   reg [15:0] intr_ff; // interrupt enable storage
   reg [7:0] lb_ff; // loop back capture
   reg [1:0] wake_en_ff; // wake monitor enables
   wire [15:0] nxt_cmd;
   wire [15:0] port_rd [0:NPORT-1];
   wire [NPORT-1:0] port_wake;
   wire [NPORT-1:0] port_abort;
   wire [NPORT-1:0] port_wr;
   wire cmd_wr = io_hit(acc_addr, `UHR_OFF_CMD);
   wire sts_wr = io_hit(acc_addr, `UHR_OFF_STS) & acc_be[0];
   // hc reset is a one shot: it clears the io map except the port connect and change bits
   wire hc_rst = cmd_ff[`UHR_CMD_HCRST];
   wire force_off = hc_rst | cmd_ff[`UHR_CMD_GRST];
   wire [7:0] pkt_lim = cmd_ff[`UHR_CMD_RECLAIM_PACKET_SIZE_SELECT] ? `UHR_PKT_BYTES_64 : `UHR_PKT_BYTES_32;
   wire [11:0] need_bits = cmd_ff[`UHR_CMD_RECLAIM_PACKET_SIZE_SELECT] ? `UHR_RECLAIM_BITS_64
                                                 : `UHR_RECLAIM_BITS_32;
   // critical window: less frame left than one full reclaim packet
   wire crit_win = frame_time_left < need_bits;
   wire babble_evt = reclaim_active & crit_win & (reclaim_bytes > pkt_lim);
   wire any_wake = |port_wake;
   // ---------------------------------------------
   // per port logic
   // ---------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NPORT; gi = gi + 1)
      begin : g_port
         assign port_wr[gi] = io_hit(acc_addr, port_off(gi));
         uhr_port u_port
         (
            .sys_clk(sys_clk),
            .rst(rst),
            .connect_pin(port_connect[gi]),
            .kstate_pin(port_kstate[gi]),
            .wr_en(port_wr[gi] & ~force_off),
            .wdata(acc_wdata),
            .force_off(force_off),
            .wake_en(wake_en_ff[gi]),
            .ctl_rd(port_rd[gi]),
            .wake_ff(port_wake[gi]),
            .abort_ff(port_abort[gi])
         );
      end
   endgenerate
   // ---------------------------------------------
   // command register next value
   // ---------------------------------------------
   // write executes command
   assign nxt_cmd = lane_merge(cmd_ff, acc_wdata, acc_be) & `UHR_CMD_MASK;
   always @(posedge sys_clk)
   begin
      if (rst | hc_rst)
      begin
         cmd_ff <= `UHR_RST_CMD;
         cmd_exec_ff <= 1'b0;
      end
      else
      begin
         cmd_exec_ff <= cmd_wr;
         if (cmd_wr)
            cmd_ff <= nxt_cmd;
         else if (xact_done & cmd_ff[`UHR_CMD_DBG])
            cmd_ff[`UHR_CMD_RUN] <= 1'b0;
         if (~cmd_wr & cmd_ff[`UHR_CMD_GRST])
            cmd_ff[`UHR_CMD_FGR] <= 1'b0;
         // resume seen during global suspend drives resume
         else if (~cmd_wr & any_wake & cmd_ff[`UHR_CMD_GSUSP])
            cmd_ff[`UHR_CMD_FGR] <= 1'b1;
      end
   end
   // ---------------------------------------------
   // status, plain storage and loop back
   // ---------------------------------------------
   always @(posedge sys_clk)
   begin
      if (rst | hc_rst)
      begin
         sts_ff <= `UHR_RST_STS;
         intr_ff <= 16'h0000;
         frame_index_ff <= 16'h0000;
         frame_base_ff <= 32'h0000_0000;
         sof_adjust_ff <= `UHR_RST_SOF;
         lb_ff <= 8'h00;
      end
      else
      begin
         // sticky flags: a new event wins over a write-one clear
         sts_ff[`UHR_STS_BABBLE] <= babble_evt
            | (sts_ff[`UHR_STS_BABBLE] & ~(sts_wr & acc_wdata[`UHR_STS_BABBLE]));
         sts_ff[`UHR_STS_RESUME] <= (any_wake & cmd_ff[`UHR_CMD_GSUSP])
            | (sts_ff[`UHR_STS_RESUME] & ~(sts_wr & acc_wdata[`UHR_STS_RESUME]));
         sts_ff[0] <= 1'b0;
         sts_ff[3] <= 1'b0;
         sts_ff[4] <= 1'b0;
         if (io_hit(acc_addr, `UHR_OFF_INTR))
            intr_ff <= lane_merge(intr_ff, acc_wdata, acc_be);
         if (io_hit(acc_addr, `UHR_OFF_FRNO))
            frame_index_ff <= lane_merge(frame_index_ff, acc_wdata, acc_be);
         if (io_hit(acc_addr, `UHR_OFF_BASE_LO))
            frame_base_ff[15:0] <= lane_merge(frame_base_ff[15:0], acc_wdata, acc_be);
         if (io_hit(acc_addr, `UHR_OFF_BASE_HI))
            frame_base_ff[31:16] <= lane_merge(frame_base_ff[31:16], acc_wdata, acc_be);
         if (io_hit(acc_addr, `UHR_OFF_SOF) & acc_be[0])
            sof_adjust_ff <= acc_wdata[7:0];
         if (lb_rx_stb & cmd_ff[`UHR_CMD_LOOP])
            lb_ff <= lb_rx_data;
      end
   end
   // ---------------------------------------------
   // configuration space wake byte
   // ---------------------------------------------
   // not touched by hc reset: it must survive to arm wakeup
   always @(posedge sys_clk)
   begin
      if (rst)
         wake_en_ff <= `UHR_RST_WAKE;
      else if (acc_wr & cfg_sel & (acc_addr == `UHR_OFF_WAKE) & acc_be[0])
         wake_en_ff <= acc_wdata[1:0];
   end
   // ---------------------------------------------
   // read path, registered
   // ---------------------------------------------
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         acc_rdata_ff <= 16'h0000;
         acc_rvalid_ff <= 1'b0;
      end
      else
      begin
         acc_rvalid_ff <= acc_rd;
         if (acc_rd & cfg_sel)
         begin
            if (acc_addr == `UHR_OFF_WAKE)
               acc_rdata_ff <= {14'h0000, wake_en_ff};
            else
               acc_rdata_ff <= 16'h0000;
         end
         else if (acc_rd)
         begin
            case ({acc_addr[7:1], 1'b0})
               `UHR_OFF_CMD: acc_rdata_ff <= cmd_ff;
               `UHR_OFF_STS: acc_rdata_ff <= {10'h000, ~run_ff, sts_ff};
               `UHR_OFF_INTR: acc_rdata_ff <= intr_ff;
               `UHR_OFF_FRNO: acc_rdata_ff <= frame_index_ff;
               `UHR_OFF_BASE_LO: acc_rdata_ff <= frame_base_ff[15:0];
               `UHR_OFF_BASE_HI: acc_rdata_ff <= frame_base_ff[31:16];
               `UHR_OFF_SOF: acc_rdata_ff <= {8'h00, sof_adjust_ff};
               `UHR_OFF_PORT0: acc_rdata_ff <= port_rd[0];
               `UHR_OFF_PORT1: acc_rdata_ff <= port_rd[1];
               `UHR_OFF_LOOP: acc_rdata_ff <= {8'h00, lb_ff};
               default: acc_rdata_ff <= 16'h0000;
            endcase
         end
      end
   end
   // ---------------------------------------------
   // engine controls and port results
   // ---------------------------------------------
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         run_ff <= 1'b0;
         cmd_out_ff <= `UHR_RST_CMD;
         start_ok_ff <= 1'b0;
         babble_ff <= 1'b0;
         stall_ep_ff <= 1'b0;
         port_enabled_ff <= {NPORT{1'b0}};
         xfer_abort_ff <= {NPORT{1'b0}};
         wake_event_ff <= 1'b0;
      end
      else
      begin
         run_ff <= cmd_ff[`UHR_CMD_RUN] & ~force_off;
         cmd_out_ff <= cmd_ff;
         start_ok_ff <= cmd_ff[`UHR_CMD_RUN] & ~crit_win;
         babble_ff <= babble_evt;
         stall_ep_ff <= babble_evt;
         port_enabled_ff <= {port_rd[1][`UHR_PC_EN], port_rd[0][`UHR_PC_EN]};
         xfer_abort_ff <= port_abort;
         wake_event_ff <= any_wake;
      end
   end
endmodule // uhr_regs
`default_nettype wire

// ### verif/uhr_usb_dev.sv
// behavioural model of the two downstream usb devices
`default_nettype none
module uhr_usb_dev
(
   // clock
   input wire logic sys_clk,
   // device line levels
   output var logic [1:0] port_connect,
   output var logic [1:0] port_kstate
);
   timeunit 1ns;
   timeprecision 1ns;
   // both devices start detached and idle
   initial
   begin
      port_connect = 2'h0;
      port_kstate = 2'h0;
   end
   // attach or detach one device just after an edge
   task automatic plug(input int p, input logic v);
      @(posedge sys_clk);
      port_connect[p] <= v;
   endtask
   // remote wakeup: k state held long enough to cross the synchroniser
   task automatic resume(input int p);
      @(posedge sys_clk);
      port_kstate[p] <= 1'b1;
      repeat (8) @(posedge sys_clk);
      port_kstate[p] <= 1'b0;
   endtask
endmodule // uhr_usb_dev
`default_nettype wire

// ### verif/uhr_regs_asserts.sv
// concurrent checks on the register front end ports
`default_nettype none
`include "uhr_defines.vh"
module uhr_regs_asserts
#(
   parameter NPORT = 2
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // register access
   input wire logic cfg_sel,
   input wire logic [7:0] acc_addr,
   input wire logic acc_wr,
   input wire logic acc_rd,
   input wire logic [1:0] acc_be,
   input wire logic [15:0] acc_wdata,
   input wire logic acc_rvalid_ff,
   // engine side
   input wire logic xact_done,
   input wire logic [11:0] frame_time_left,
   input wire logic reclaim_active,
   input wire logic [7:0] reclaim_bytes,
   input wire logic run_ff,
   input wire logic cmd_exec_ff,
   input wire logic [15:0] cmd_out_ff,
   input wire logic start_ok_ff,
   input wire logic babble_ff,
   input wire logic stall_ep_ff,
   input wire logic [7:0] sof_adjust_ff,
   input wire logic [NPORT-1:0] port_enabled_ff
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // ----------------------------------
   // helpers
   // ----------------------------------
   // cmd_out_ff lags one cycle, so sequences exclude a write just before
   wire io_cmd_wr = acc_wr && !cfg_sel && (acc_addr[7:1] == 7'h00);
   wire reclaim_packet_size_select = cmd_out_ff[`UHR_CMD_RECLAIM_PACKET_SIZE_SELECT];
   wire [11:0] need = reclaim_packet_size_select ? `UHR_RECLAIM_BITS_64 : `UHR_RECLAIM_BITS_32;
   wire [7:0] limit = reclaim_packet_size_select ? `UHR_PKT_BYTES_64 : `UHR_PKT_BYTES_32;
   sequence s_hc_rst_wr;
      io_cmd_wr && acc_be[0] && acc_wdata[`UHR_CMD_HCRST];
   endsequence
   sequence s_step_done;
      cmd_out_ff[`UHR_CMD_DBG] && xact_done && !acc_wr && !$past(acc_wr);
   endsequence
   sequence s_oversize;
      reclaim_active && frame_time_left < need && reclaim_bytes > limit && !$past(acc_wr);
   endsequence
   // ----------------------------------
   // properties
   // ----------------------------------
   // write executes command
   a_cmd_exec_pulse: assert property (io_cmd_wr |=> cmd_exec_ff)
      else $error("command write gave no execute pulse");
   a_sof_reset_val: assert property ($fell(rst) |-> sof_adjust_ff == `UHR_RST_SOF)
      else $error("frame start adjust not 40h after reset");
   a_hc_rst_abort: assert property (s_hc_rst_wr |-> ##[1:4] port_enabled_ff == '0)
      else $error("controller reset left a port enabled");
   a_debug_step_stop: assert property (s_step_done |=> ##1 !run_ff)
      else $error("debug mode kept running after a transaction");
   a_babble_flag: assert property (s_oversize |=> babble_ff)
      else $error("oversize reclaim packet gave no babble");
   a_stall_pair: assert property (stall_ep_ff == babble_ff)
      else $error("stall and babble disagree");
   a_start_blocked: assert property
      (frame_time_left < 12'h100 && $past(frame_time_left) < 12'h100 |=> !start_ok_ff)
      else $error("start allowed with too little frame time");
   a_read_answer: assert property (acc_rvalid_ff == $past(acc_rd))
      else $error("read answer pulse misplaced");
endmodule // uhr_regs_asserts
bind uhr_regs uhr_regs_asserts #(.NPORT(NPORT)) i_chk (.sys_clk, .rst, .cfg_sel, .acc_addr,
   .acc_wr, .acc_rd, .acc_be, .acc_wdata, .acc_rvalid_ff, .xact_done, .frame_time_left,
   .reclaim_active, .reclaim_bytes, .run_ff, .cmd_exec_ff, .cmd_out_ff, .start_ok_ff,
   .babble_ff, .stall_ep_ff, .sof_adjust_ff, .port_enabled_ff);
`default_nettype wire

// ### verif/tb.sv
// self-checking bench for the register front end
`default_nettype none
`include "uhr_defines.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic cfg_sel = 1'b0;
   logic [7:0] acc_addr = 8'h00;
   logic acc_wr = 1'b0;
   logic acc_rd = 1'b0;
   logic [1:0] acc_be = 2'h3;
   logic [15:0] acc_wdata = 16'h0000;
   logic xact_done = 1'b0;
   logic [11:0] frame_time_left = 12'h000;
   logic reclaim_active = 1'b0;
   logic [7:0] reclaim_bytes = 8'h00;
   logic lb_rx_stb = 1'b0;
   logic [7:0] lb_rx_data = 8'h00;
   wire [1:0] port_connect, port_kstate, port_enabled_ff, xfer_abort_ff;
   wire [15:0] acc_rdata_ff, frame_index_ff;
   wire [31:0] frame_base_ff;
   wire acc_rvalid_ff, run_ff, cmd_exec_ff, start_ok_ff, babble_ff, wake_event_ff;
   int fails = 0;
   int checks = 0;
   int n_wake = 0;
   int n_bab = 0;
   int n_abort = 0;
   logic [15:0] rv;
   uhr_regs #(.NPORT(2)) i_dut (.sys_clk, .rst, .cfg_sel, .acc_addr, .acc_wr, .acc_rd,
      .acc_be, .acc_wdata, .acc_rdata_ff, .acc_rvalid_ff, .port_connect, .port_kstate,
      .xact_done, .frame_time_left, .reclaim_active, .reclaim_bytes, .lb_rx_stb,
      .lb_rx_data, .run_ff, .cmd_exec_ff, .cmd_out_ff(), .start_ok_ff, .babble_ff,
      .stall_ep_ff(), .sof_adjust_ff(), .frame_base_ff, .frame_index_ff,
      .port_enabled_ff, .xfer_abort_ff, .wake_event_ff);
   uhr_usb_dev i_dev (.sys_clk, .port_connect, .port_kstate);
   // 100 ns period
   always #50 sys_clk = ~sys_clk;
   // event pulse counters
   always @(posedge sys_clk)
   begin
      if (wake_event_ff === 1'b1) n_wake++;
      if (babble_ff === 1'b1) n_bab++;
      if (xfer_abort_ff !== 2'h0) n_abort++;
   end
   // ----------------------------------
   // bus and compare tasks
   // ----------------------------------
   task automatic chkw(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t word %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t flag %b want %b", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // whole-word writes keep port registers predictable
   task automatic wr(input logic c, input logic [7:0] a, input logic [15:0] d,
      input logic [1:0] be);
      @(posedge sys_clk);
      cfg_sel <= c;
      acc_addr <= a;
      acc_wdata <= d;
      acc_be <= be;
      acc_wr <= 1'b1;
      @(posedge sys_clk);
      acc_wr <= 1'b0;
   endtask
   // answer stands just after the taking edge
   task automatic rd(input logic c, input logic [7:0] a);
      @(posedge sys_clk);
      cfg_sel <= c;
      acc_addr <= a;
      acc_rd <= 1'b1;
      @(posedge sys_clk);
      acc_rd <= 1'b0;
      #1;
      chk1(acc_rvalid_ff, 1'b1);
      rv = acc_rdata_ff;
   endtask
   task automatic end_sim();
      if (fails == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ----------------------------------
   // scenarios
   // ----------------------------------
   task automatic t_reset_vals();
      logic [7:0] offs [7] = '{`UHR_OFF_CMD, `UHR_OFF_SOF, `UHR_OFF_PORT0, `UHR_OFF_PORT1,
         `UHR_OFF_LOOP, 8'h0e, 8'h14};
      logic [15:0] exps [7] = '{16'h0, 16'h0040, 16'h0080, 16'h0080, 16'h0, 16'h0, 16'h0};
      for (int i = 0; i < 7; i++)
      begin
         rd(1'b0, offs[i]);
         chkw(rv, exps[i]);
      end
      rd(1'b1, `UHR_OFF_WAKE);
      chkw(rv, 16'h0000);
      wr(1'b1, `UHR_OFF_WAKE, 16'h00ff, 2'h3);
      rd(1'b1, `UHR_OFF_WAKE);
      chkw(rv, 16'h0003);
      rd(1'b1, 8'hc0);
      chkw(rv, 16'h0000);
      wr(1'b0, `UHR_OFF_SOF, 16'h0022, 2'h1);
      rd(1'b0, `UHR_OFF_SOF);
      chkw(rv, 16'h0022);
   endtask
   // toggle attach, or signal resume, then look for a wake pulse
   task automatic t_wake(input logic [1:0] en, input int p, input logic exp, input logic k);
      int b;
      wr(1'b1, `UHR_OFF_WAKE, {14'h0, en}, 2'h3);
      // remote wakeup only counts on a suspended port
      if (k)
         wr(1'b0, p ? `UHR_OFF_PORT1 : `UHR_OFF_PORT0, 16'h1000, 2'h3);
      b = n_wake;
      if (k)
         i_dev.resume(p);
      else
         i_dev.plug(p, ~port_connect[p]);
      cyc(10);
      chk1(n_wake != b, exp);
   endtask
   task automatic t_port();
      int b;
      i_dev.plug(0, 1'b1);
      cyc(8);
      rd(1'b0, `UHR_OFF_PORT0);
      chk1(rv[`UHR_PC_CONN], 1'b1);
      wr(1'b0, `UHR_OFF_PORT0, 16'h0004, 2'h3);
      rd(1'b0, `UHR_OFF_PORT0);
      chk1(rv[`UHR_PC_EN], 1'b1);
      wr(1'b0, `UHR_OFF_PORT0, 16'h0200, 2'h3);
      cyc(4);
      chk1(port_enabled_ff[0], 1'b0);
      // port reset holds until software ends it, only then enable sticks
      wr(1'b0, `UHR_OFF_PORT0, 16'h0000, 2'h3);
      wr(1'b0, `UHR_OFF_PORT0, 16'h0004, 2'h3);
      cyc(2);
      chk1(port_enabled_ff[0], 1'b1);
      b = n_abort;
      wr(1'b0, `UHR_OFF_CMD, 16'h0002, 2'h3);
      cyc(6);
      chkw({14'h0, port_enabled_ff}, 16'h0000);
      chk1(n_abort != b, 1'b1);
      rd(1'b0, `UHR_OFF_PORT0);
      chk1(rv[`UHR_PC_EN], 1'b0);
      // global reset must abort and disable as well
      wr(1'b0, `UHR_OFF_PORT0, 16'h0004, 2'h3);
      cyc(2);
      chk1(port_enabled_ff[0], 1'b1);
      b = n_abort;
      wr(1'b0, `UHR_OFF_CMD, 16'h0004, 2'h3);
      cyc(6);
      chk1(port_enabled_ff[0], 1'b0);
      chk1(n_abort != b, 1'b1);
      wr(1'b0, `UHR_OFF_CMD, 16'hfe80, 2'h3);
      rd(1'b0, `UHR_OFF_CMD);
      chkw(rv, 16'h0080);
   endtask
   // one reclamation cycle of the given size
   task automatic bab(input logic [7:0] sz, input logic exp);
      int b;
      b = n_bab;
      @(posedge sys_clk);
      reclaim_bytes <= sz;
      reclaim_active <= 1'b1;
      @(posedge sys_clk);
      reclaim_active <= 1'b0;
      cyc(3);
      chk1(n_bab != b, exp);
   endtask
   task automatic t_reclaim(input logic mp);
      wr(1'b0, `UHR_OFF_CMD, {8'h0, mp, 7'h01}, 2'h3);
      frame_time_left <= 12'h100;
      cyc(4);
      chk1(start_ok_ff, ~mp);
      frame_time_left <= 12'h0ff;
      cyc(4);
      chk1(start_ok_ff, 1'b0);
      bab(mp ? 8'h40 : 8'h20, 1'b0);
      bab(mp ? 8'h41 : 8'h21, 1'b1);
      // babble is sticky until written one, halted reads low while running
      rd(1'b0, `UHR_OFF_STS);
      chkw(rv, 16'h0002);
      wr(1'b0, `UHR_OFF_STS, 16'h0002, 2'h3);
      rd(1'b0, `UHR_OFF_STS);
      chkw(rv, 16'h0000);
   endtask
   // plain storage words, partial lanes and a reserved hole
   task automatic t_frame();
      wr(1'b0, `UHR_OFF_FRNO, 16'h1234, 2'h3);
      wr(1'b0, `UHR_OFF_BASE_LO, 16'h5678, 2'h3);
      wr(1'b0, `UHR_OFF_BASE_HI, 16'h9abc, 2'h3);
      wr(1'b0, `UHR_OFF_BASE_LO, 16'hff00, 2'h2);
      wr(1'b0, `UHR_OFF_INTR, 16'h000f, 2'h1);
      rd(1'b0, `UHR_OFF_FRNO);
      chkw(rv, 16'h1234);
      chkw(frame_index_ff, 16'h1234);
      chkw(frame_base_ff[31:16], 16'h9abc);
      chkw(frame_base_ff[15:0], 16'hff78);
      rd(1'b0, `UHR_OFF_INTR);
      chkw(rv, 16'h000f);
      rd(1'b0, 8'h16);
      chkw(rv, 16'h0000);
   endtask
   task automatic t_debug();
      wr(1'b0, `UHR_OFF_CMD, 16'h0020, 2'h3);
      wr(1'b0, `UHR_OFF_CMD, 16'h0021, 2'h3);
      cyc(3);
      chk1(run_ff, 1'b1);
      xact_done <= 1'b1;
      @(posedge sys_clk);
      xact_done <= 1'b0;
      cyc(3);
      chk1(run_ff, 1'b0);
      rd(1'b0, `UHR_OFF_CMD);
      chkw(rv, 16'h0020);
   endtask
   task automatic t_loop();
      wr(1'b0, `UHR_OFF_CMD, 16'h0100, 2'h3);
      lb_rx_data <= 8'h5a;
      lb_rx_stb <= 1'b1;
      @(posedge sys_clk);
      lb_rx_stb <= 1'b0;
      rd(1'b0, `UHR_OFF_LOOP);
      chkw(rv, 16'h005a);
   endtask
   // main sequence
   initial
   begin
      cyc(20);
      rst <= 1'b0;
      t_reset_vals();
      t_wake(2'h0, 0, 1'b0, 1'b0);
      t_wake(2'h1, 0, 1'b1, 1'b0);
      t_wake(2'h1, 1, 1'b0, 1'b0);
      t_wake(2'h3, 1, 1'b1, 1'b0);
      t_port();
      t_wake(2'h1, 0, 1'b1, 1'b1);
      t_reclaim(1'b0);
      t_reclaim(1'b1);
      t_debug();
      t_loop();
      t_frame();
      end_sim();
   end
   // watchdog well beyond the roughly 260 cycles the tests need
   initial
   begin
      #(100 * 5000);
      fails++;
      end_sim();
   end
endmodule // tb
`default_nettype wire
